// File: shared/sec_phase_map.svh
// Offsets, fields, reset values and counts of the phase adjust block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus.
`ifndef SEC_PHASE_MAP_SVH
`define SEC_PHASE_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define REG_CTRL_OFS 8'h00
`define REG_PERIOD_OFS 8'h04
`define REG_OFFSET_OFS 8'h08
`define REG_STATUS_OFS 8'h0C
`define REG_RXDATA_OFS 8'h10
`define REG_TXDATA_OFS 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_RUN_BIT 0
`define STAT_PEND_BIT 0
`define STAT_DIR_BIT 1
`define STAT_CMD_LSB 2
`define STAT_CMD_MSB 3
`define STAT_IGN_BIT 4
`define STAT_XCNT_LSB 8
`define STAT_XCNT_MSB 15
`define WORD_CTL_HIGH_BIT 15
`define WORD_CTL_LOW_BIT 14
`define DAC_MSB 15
`define DAC_LSB 2

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define CTRL_RESET 1'h1
`define PERIOD_RESET 16'h0100
`define OFFSET_RESET 8'h00
`define TXDATA_RESET 16'h0000
`define WORD_BITS 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: shared/sec_phase_pkg.sv
// Types shared by the secondary-word phase adjust design files.
// Assumes the constants of sec_phase_map.svh are included where needed.
`default_nettype none

package sec_phase_pkg;

    // Decoded secondary-word command
    typedef enum logic [1:0] {
        CMD_IGNORE = 2'b00,
        CMD_EXCHANGE = 2'b01,
        CMD_DELAY = 2'b10,
        CMD_ADVANCE = 2'b11
    } cmd_t;

    // Frame engine state
    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_SHIFT = 2'b01,
        FR_DONE = 2'b10
    } frame_state_t;

endpackage

`default_nettype wire

// File: design/sec_cmd_decode.sv
// Combinational decode of the two secondary-word control bits and the two
// function-code pins into one command, with the offset sign folded in.
// Assumes inputs are synchronous; the caller registers all but the two function-code pins.
`default_nettype none

module sec_cmd_decode
(
    input wire logic sec_ctl_bit_high,
    input wire logic sec_ctl_bit_low,
    input wire logic func_code_pin_high,
    input wire logic func_code_pin_low,
    input wire logic offset_neg,
    output var sec_phase_pkg::cmd_t cmd
);

    sec_phase_pkg::cmd_t raw_cmd;

    always_comb
    begin
        raw_cmd = sec_phase_pkg::CMD_IGNORE; // (RQ1)
        casez ({sec_ctl_bit_high, sec_ctl_bit_low, func_code_pin_high, func_code_pin_low})
            4'b00??:
                raw_cmd = sec_phase_pkg::CMD_EXCHANGE; // (RQ2)
            4'b01??:
                raw_cmd = sec_phase_pkg::CMD_DELAY; // (RQ3)
            4'b10??:
                raw_cmd = sec_phase_pkg::CMD_ADVANCE; // (RQ4)
            4'b1101:
                raw_cmd = sec_phase_pkg::CMD_DELAY; // (RQ6)
            4'b1110:
                raw_cmd = sec_phase_pkg::CMD_ADVANCE; // (RQ7)
            4'b1100, 4'b1111:
                raw_cmd = sec_phase_pkg::CMD_EXCHANGE; // (RQ8)
            default:
                raw_cmd = sec_phase_pkg::CMD_IGNORE; // (RQ1)
        endcase
    end

    // A negative offset turns the requested direction round
    always_comb
    begin
        cmd = raw_cmd;
        if (offset_neg && raw_cmd == sec_phase_pkg::CMD_DELAY)
        begin
            cmd = sec_phase_pkg::CMD_ADVANCE; // (RQ5)
        end
        else if (offset_neg && raw_cmd == sec_phase_pkg::CMD_ADVANCE)
        begin
            cmd = sec_phase_pkg::CMD_DELAY; // (RQ5)
        end
    end

endmodule

`default_nettype wire

// File: design/word_shifter.sv
// Parallel-load, MSB-first shift register for both link directions.
// Assumes load and shift never come in the same cycle.
`default_nettype none

module word_shifter
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic shift,
    input wire logic ser_in,
    output logic [WIDTH-1:0] q
);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else if (load)
        begin
            q <= load_val;
        end
        else if (shift)
        begin
            q <= {q[WIDTH-2:0], ser_in};
        end
    end

endmodule

`default_nettype wire

// File: design/secondary_word_phase_adjust.sv
// Secondary communication word decoder with one-shot sampling phase shift,
// serial word exchange engine and AXI4-Lite register slave.
// Assumes all pins are synchronous to CLK and one data bit moves per CLK.
//
// Summary of operation
// (RQ1) Undecoded bit and pin combinations cause nothing.
// (RQ2) Control bits 00: plain exchange, pins ignored.
// (RQ3) Control bits 01: delay next sample by offset.
// (RQ4) Control bits 10: advance next sample by offset.
// (RQ5) Negative offset reverses the shift direction.
// (RQ6) Bits 11, pins 01: delay next sample.
// (RQ7) Bits 11, pins 10: advance next sample.
// (RQ8) Bits 11, pins 00 or 11: plain exchange.
// (RQ9) Each shift affects one sampling period only.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`include "sec_phase_map.svh"
`default_nettype none

module secondary_word_phase_adjust
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic FRAME_SYNC_N,
    input wire logic SECONDARY_FRAME,
    input wire logic DATA_IN,
    output logic DATA_OUT,
    input wire logic FUNC_CODE_PIN_HIGH,
    input wire logic FUNC_CODE_PIN_LOW,
    output logic SAMPLE_TICK,
    input wire logic [7:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic run_ff;
    logic [15:0] period_ff;
    logic [7:0] offset_ff;
    logic [15:0] tx_word_ff;
    logic [13:0] dac_word_ff;
    logic fs_prev_ff;
    logic fs_fall;
    logic fs_rise;
    sec_phase_pkg::frame_state_t state_ff;
    logic [4:0] bit_cnt_ff;
    logic sec_frame_ff;
    logic shifting;
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    sec_phase_pkg::cmd_t dec_cmd;
    sec_phase_pkg::cmd_t last_cmd_ff;
    logic ignored_ff;
    logic [7:0] xchg_cnt_ff;
    logic pend_ff;
    logic pend_delay_ff;
    logic word_done;
    logic new_req;
    logic [8:0] amount;
    logic [16:0] cnt_ff;
    logic [16:0] nxt_cnt;
    logic [16:0] base_cnt;
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic do_write;
    logic wr_hit;

    // ------------------------------------------------------------------------
    // Frame sync edges
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            fs_prev_ff <= 1'b1;
        end
        else
        begin
            fs_prev_ff <= FRAME_SYNC_N;
        end
    end

    assign fs_fall = fs_prev_ff && !FRAME_SYNC_N;
    assign fs_rise = !fs_prev_ff && FRAME_SYNC_N;

    // ------------------------------------------------------------------------
    // Word exchange engine
    // ------------------------------------------------------------------------
    // A new falling edge in mid-word restarts the word; the host owns framing.
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            state_ff <= sec_phase_pkg::FR_IDLE;
            bit_cnt_ff <= 5'h00;
            sec_frame_ff <= 1'b0;
        end
        else if (fs_fall)
        begin
            state_ff <= sec_phase_pkg::FR_SHIFT;
            bit_cnt_ff <= `WORD_BITS;
            sec_frame_ff <= SECONDARY_FRAME;
        end
        else
        begin
            case (state_ff)
                sec_phase_pkg::FR_SHIFT:
                begin
                    bit_cnt_ff <= bit_cnt_ff - 5'h01;
                    if (bit_cnt_ff == 5'h01)
                    begin
                        state_ff <= sec_phase_pkg::FR_DONE;
                    end
                end
                sec_phase_pkg::FR_DONE:
                    state_ff <= sec_phase_pkg::FR_IDLE;
                default:
                    state_ff <= sec_phase_pkg::FR_IDLE;
            endcase
        end
    end

    assign shifting = (state_ff == sec_phase_pkg::FR_SHIFT) && !fs_fall;
    assign word_done = (state_ff == sec_phase_pkg::FR_DONE) && !fs_fall;

    word_shifter #(.WIDTH(16)) rx_shift
    (
        .clk(CLK),
        .rst_n(RESETN),
        .load(1'b0),
        .load_val(16'h0000),
        .shift(shifting),
        .ser_in(DATA_IN),
        .q(rx_q)
    );

    // Secondary frames carry no converter data back to the host
    word_shifter #(.WIDTH(16)) tx_shift
    (
        .clk(CLK),
        .rst_n(RESETN),
        .load(fs_fall),
        .load_val(SECONDARY_FRAME ? 16'h0000 : tx_word_ff),
        .shift(shifting),
        .ser_in(1'b0),
        .q(tx_q)
    );

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            DATA_OUT <= 1'b0;
        end
        else
        begin
            DATA_OUT <= (fs_fall || shifting) ? tx_q[15] : 1'b0;
        end
    end

    // Primary words deliver the 14 converter bits; the two low bits stay out
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            dac_word_ff <= 14'h0000;
            xchg_cnt_ff <= 8'h00;
        end
        else if (word_done && !sec_frame_ff)
        begin
            dac_word_ff <= rx_q[`DAC_MSB:`DAC_LSB]; // (RQ2)
            xchg_cnt_ff <= xchg_cnt_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Secondary word decode
    // ------------------------------------------------------------------------
    sec_cmd_decode cmd_dec
    (
        .sec_ctl_bit_high(rx_q[`WORD_CTL_HIGH_BIT]),
        .sec_ctl_bit_low(rx_q[`WORD_CTL_LOW_BIT]),
        .func_code_pin_high(FUNC_CODE_PIN_HIGH),
        .func_code_pin_low(FUNC_CODE_PIN_LOW),
        .offset_neg(offset_ff[7]),
        .cmd(dec_cmd)
    );

    assign new_req = word_done && sec_frame_ff &&
        (dec_cmd == sec_phase_pkg::CMD_DELAY || dec_cmd == sec_phase_pkg::CMD_ADVANCE);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            last_cmd_ff <= sec_phase_pkg::CMD_IGNORE;
            ignored_ff <= 1'b0;
        end
        else if (word_done && sec_frame_ff)
        begin
            last_cmd_ff <= dec_cmd;
            ignored_ff <= (dec_cmd == sec_phase_pkg::CMD_IGNORE); // (RQ1)
        end
    end

    // A request arriving on the very edge that consumes the old one survives
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            pend_ff <= 1'b0;
            pend_delay_ff <= 1'b0;
        end
        else if (new_req)
        begin
            pend_ff <= 1'b1;
            pend_delay_ff <= (dec_cmd == sec_phase_pkg::CMD_DELAY); // (RQ3) (RQ4) (RQ6) (RQ7)
        end
        else if (fs_rise)
        begin
            pend_ff <= 1'b0; // (RQ9)
        end
    end

    // ------------------------------------------------------------------------
    // Sampling period counter
    // ------------------------------------------------------------------------
    // Magnitude needs nine bits so that the most negative offset fits
    assign amount = offset_ff[7] ? 9'(-{offset_ff[7], offset_ff}) : {1'b0, offset_ff}; // (RQ5)

    always_comb
    begin
        base_cnt = (cnt_ff == 17'h00000) ? {1'b0, period_ff - 16'h0001} : cnt_ff - 17'h00001;
        nxt_cnt = base_cnt;
        if (fs_rise && pend_ff && !new_req)
        begin
            if (pend_delay_ff)
            begin
                nxt_cnt = base_cnt + {8'h00, amount}; // (RQ3) (RQ6)
            end
            else if (base_cnt > {8'h00, amount})
            begin
                nxt_cnt = base_cnt - {8'h00, amount}; // (RQ4) (RQ7)
            end
            else
            begin
                nxt_cnt = 17'h00000;
            end
        end
    end

    // The shift only moves the count in flight, so later periods are nominal
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            cnt_ff <= 17'h00000;
            SAMPLE_TICK <= 1'b0;
        end
        else if (!run_ff)
        begin
            cnt_ff <= 17'h00000;
            SAMPLE_TICK <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt; // (RQ9)
            SAMPLE_TICK <= (cnt_ff == 17'h00000);
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    assign do_write = aw_held_ff && w_held_ff && !BVALID;
    assign wr_hit = (aw_addr_ff == `REG_CTRL_OFS) || (aw_addr_ff == `REG_PERIOD_OFS) ||
        (aw_addr_ff == `REG_OFFSET_OFS) || (aw_addr_ff == `REG_TXDATA_OFS);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= AWADDR;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
                WREADY <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            run_ff <= `CTRL_RESET;
            period_ff <= `PERIOD_RESET;
            offset_ff <= `OFFSET_RESET;
            tx_word_ff <= `TXDATA_RESET;
        end
        else if (do_write)
        begin
            if (aw_addr_ff == `REG_CTRL_OFS)
            begin
                if (w_strb_ff[0])
                    run_ff <= w_data_ff[`CTRL_RUN_BIT];
            end
            else if (aw_addr_ff == `REG_PERIOD_OFS)
            begin
                if (w_strb_ff[0])
                    period_ff[7:0] <= w_data_ff[7:0];
                if (w_strb_ff[1])
                    period_ff[15:8] <= w_data_ff[15:8];
            end
            else if (aw_addr_ff == `REG_OFFSET_OFS)
            begin
                if (w_strb_ff[0])
                    offset_ff <= w_data_ff[7:0];
            end
            else if (aw_addr_ff == `REG_TXDATA_OFS)
            begin
                if (w_strb_ff[0])
                    tx_word_ff[7:0] <= w_data_ff[7:0];
                if (w_strb_ff[1])
                    tx_word_ff[15:8] <= w_data_ff[15:8];
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= `RESP_OKAY;
            RDATA <= 32'h00000000;
            if (ARADDR == `REG_CTRL_OFS)
                RDATA[`CTRL_RUN_BIT] <= run_ff;
            else if (ARADDR == `REG_PERIOD_OFS)
                RDATA[15:0] <= period_ff;
            else if (ARADDR == `REG_OFFSET_OFS)
                RDATA[7:0] <= offset_ff;
            else if (ARADDR == `REG_STATUS_OFS)
            begin
                RDATA[`STAT_PEND_BIT] <= pend_ff;
                RDATA[`STAT_DIR_BIT] <= pend_delay_ff;
                RDATA[`STAT_CMD_MSB:`STAT_CMD_LSB] <= last_cmd_ff;
                RDATA[`STAT_IGN_BIT] <= ignored_ff;
                RDATA[`STAT_XCNT_MSB:`STAT_XCNT_LSB] <= xchg_cnt_ff;
            end
            else if (ARADDR == `REG_RXDATA_OFS)
                RDATA[13:0] <= dac_word_ff;
            else if (ARADDR == `REG_TXDATA_OFS)
                RDATA[15:0] <= tx_word_ff;
            else
                RRESP <= `RESP_SLVERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: tb/sec_phase_checker.sv
// Concurrent checks on the ports of the secondary-word phase adjust block.
// Assumes one clock domain and the register map header on the include path.
`include "sec_phase_map.svh"
`default_nettype none

module sec_phase_checker
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic FRAME_SYNC_N,
    input wire logic SECONDARY_FRAME,
    input wire logic DATA_OUT,
    input wire logic SAMPLE_TICK,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    // ------------------------------------------------------------------
    // Bus and link relations
    // ------------------------------------------------------------------
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write response late");
    a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("bresp not held");
    a_write_block: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while busy");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data late");
    a_rdata_hold: assert property (RVALID && !RREADY |=>
        RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("rdata not held");
    a_read_refuse: assert property (ARVALID && ARREADY && ARADDR >= 8'h18 |=>
        RRESP == `RESP_SLVERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_tick_pulse: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
        else $error("tick too long");
    // Control words carry no converter data, so the return line stays low
    a_sec_quiet: assert property ($fell(FRAME_SYNC_N) && SECONDARY_FRAME |=>
        ##1 !DATA_OUT [*8] ##1 !DATA_OUT [*8])
        else $error("data sent during control word");
endmodule

bind secondary_word_phase_adjust sec_phase_checker sec_phase_checker_inst
(
    .CLK(CLK), .RESETN(RESETN), .FRAME_SYNC_N(FRAME_SYNC_N),
    .SECONDARY_FRAME(SECONDARY_FRAME), .DATA_OUT(DATA_OUT), .SAMPLE_TICK(SAMPLE_TICK),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY)
);

`default_nettype wire

// File: tb/host_port_model.sv
// Host serial port model: frames one 16-bit word MSB first and captures
// the returned word. Assumes one bit per rising edge of clk.
`default_nettype none

module host_port_model
(
    input wire logic clk,
    output logic frame_sync_n,
    output logic secondary_frame,
    output logic data_in,
    input wire logic data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        frame_sync_n = 1'b1;
        secondary_frame = 1'b0;
        data_in = 1'b0;
    end

    // ------------------------------------------------------------------
    // Word transfer
    // ------------------------------------------------------------------
    // Sync stays low past the word-done cycle so its rising edge finds the request latched
    task automatic send_word(input logic sec, input logic [15:0] word, output logic [15:0] rx);
        @(posedge clk);
        frame_sync_n <= 1'b0;
        secondary_frame <= sec;
        // Returned bits trail sent ones by a cycle; the last edge drives the complement of bit 0
        for (int i = 16; i >= 0; i--)
        begin
            @(posedge clk);
            data_in <= (i > 0) ? word[i - 1] : ~word[0];
            #1 if (i < 16) rx[i] = data_out;
        end
        repeat (2) @(posedge clk);
        frame_sync_n <= 1'b1;
        secondary_frame <= 1'b0;
    endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: registers over AXI4-Lite, words through the host
// model, sample instants timed by cycle count. Assumes CLK at 20 MHz.
`include "sec_phase_map.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PER = 64;
    logic CLK, RESETN, FRAME_SYNC_N, SECONDARY_FRAME, DATA_IN, DATA_OUT, SAMPLE_TICK;
    logic FUNC_CODE_PIN_HIGH, FUNC_CODE_PIN_LOW;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, rd;
    logic [1:0] BRESP, RRESP, rresp;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY;
    logic [15:0] rx;
    int miscompares, compares, cyc, t0;
    // Bits 3:2 control bits, bits 1:0 function pins
    logic [3:0] combo [9] = '{4'h1, 4'h6, 4'h9, 4'hD, 4'hE, 4'hC, 4'hF, 4'h6, 4'h9};
    int shift [9] = '{0, 5, -5, 5, -5, 0, 0, -5, 5};
    logic [1:0] cmds [9] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h1, 2'h3, 2'h2};

    secondary_word_phase_adjust secondary_word_phase_adjust_inst
    (
        .CLK(CLK), .RESETN(RESETN), .FRAME_SYNC_N(FRAME_SYNC_N),
        .SECONDARY_FRAME(SECONDARY_FRAME), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
        .FUNC_CODE_PIN_HIGH(FUNC_CODE_PIN_HIGH), .FUNC_CODE_PIN_LOW(FUNC_CODE_PIN_LOW),
        .SAMPLE_TICK(SAMPLE_TICK), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY)
    );

    host_port_model host_port_model_inst
    (
        .clk(CLK), .frame_sync_n(FRAME_SYNC_N), .secondary_frame(SECONDARY_FRAME),
        .data_in(DATA_IN), .data_out(DATA_OUT)
    );

    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    always @(posedge CLK) cyc <= cyc + 1;

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        $display("MISMATCH t=%0t wait ran out", $time);
        final_report();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
        input logic [1:0] resp);
        int n = 0;
        @(posedge CLK);
        AWADDR <= addr;
        WDATA <= data;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (AWVALID && AWREADY)
                AWVALID <= 1'b0;
            if (WVALID && WREADY)
                WVALID <= 1'b0;
            if (++n > 100)
                hang();
        end
        while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        check(32'(BRESP), 32'(resp));
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data);
        int n = 0;
        @(posedge CLK);
        ARADDR <= addr;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (ARVALID && ARREADY)
                ARVALID <= 1'b0;
            if (++n > 100)
                hang();
        end
        while (RVALID !== 1'b1);
        data = RDATA;
        rresp = RRESP;
        RREADY <= 1'b0;
    endtask

    task automatic read_check(input logic [7:0] addr, input logic [31:0] exp,
        input logic [1:0] resp);
        axi_read(addr, rd);
        check(rd, exp);
        check(32'(rresp), 32'(resp));
    endtask

    // Ticks are looked at after the edge has landed
    task automatic wait_tick();
        int n = 0;
        do
        begin
            @(posedge CLK);
            #1;
            if (++n > 300)
                hang();
        end
        while (SAMPLE_TICK !== 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
        {FUNC_CODE_PIN_HIGH, FUNC_CODE_PIN_LOW, AWADDR, ARADDR, WDATA} = 50'h0;
        cyc = 0;
        repeat (6) @(posedge CLK);
        RESETN <= 1'b1;
        read_check(`REG_CTRL_OFS, 32'(`CTRL_RESET), `RESP_OKAY);
        read_check(`REG_PERIOD_OFS, 32'(`PERIOD_RESET), `RESP_OKAY);
        read_check(`REG_OFFSET_OFS, 32'(`OFFSET_RESET), `RESP_OKAY);
        read_check(`REG_TXDATA_OFS, 32'(`TXDATA_RESET), `RESP_OKAY);
        read_check(8'h20, 32'h0, `RESP_SLVERR);
        axi_write(8'h20, 32'h1, `RESP_SLVERR);
        axi_write(`REG_STATUS_OFS, 32'h1, `RESP_SLVERR);
        axi_write(`REG_PERIOD_OFS, 32'(PER), `RESP_OKAY);
        axi_write(`REG_OFFSET_OFS, 32'h5, `RESP_OKAY);
        axi_write(`REG_TXDATA_OFS, 32'hA5C3, `RESP_OKAY);
        wait_tick();
        t0 = cyc;
        host_port_model_inst.send_word(1'b0, 16'h1234, rx);
        check(32'(rx), 32'hA5C3);
        read_check(`REG_RXDATA_OFS, 32'h048D, `RESP_OKAY);
        wait_tick();
        check(32'(cyc - t0), 32'(PER));
        for (int k = 0; k < 9; k++)
        begin
            axi_write(`REG_OFFSET_OFS, (k > 6) ? 32'hFB : 32'h5, `RESP_OKAY);
            FUNC_CODE_PIN_HIGH <= combo[k][1];
            FUNC_CODE_PIN_LOW <= combo[k][0];
            wait_tick();
            t0 = cyc;
            host_port_model_inst.send_word(1'b1, {combo[k][3:2], 14'h2AAA}, rx);
            check(32'(rx), 32'h0);
            axi_read(`REG_STATUS_OFS, rd);
            check(32'(rd[3:2]), 32'(cmds[k]));
            wait_tick();
            check(32'(cyc - t0), 32'(PER + shift[k]));
            t0 = cyc;
            wait_tick();
            check(32'(cyc - t0), 32'(PER));
        end
        final_report();
    end
endmodule

`default_nettype wire
